// File: rtl/cgc_pkg.sv
package cgc_pkg;
   // Register byte addresses (word aligned except ADDR_PCLK, one register per word)
   localparam logic [7:0] ADDR_PCLK = 8'h12;
   localparam logic [7:0] ADDR_PROT = 8'h00;
   localparam logic [7:0] ADDR_CTL0 = 8'h04;
   localparam logic [7:0] ADDR_CTL1 = 8'h08;
   localparam logic [7:0] ADDR_CTL2 = 8'h0c;
   localparam logic [7:0] ADDR_MODE = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   // Printed offset 0x12 is not word aligned: it is an index
   localparam logic [7:0] IDX_PCLK = 8'h12;
   localparam logic [9:0] BADDR_PCLK = {IDX_PCLK, 2'b00};
   // Protect register
   localparam int PROT_UNLOCK = 0;
   // Control 0
   localparam int C0_MAIN_WAIT = 2;
   localparam int C0_SUB_DRV = 3;
   localparam int C0_SUB_PIN = 4;
   localparam int C0_MAIN_STOP = 5;
   localparam int C0_DIV8 = 6;
   localparam int C0_SUB_SEL = 7;
   localparam logic [7:0] CTL0_RST = 8'h48;
   // Control 1
   localparam int C1_STOP = 0;
   localparam int C1_PLL_SEL = 1;
   localparam int C1_LOCO_OFF = 4;
   localparam int C1_MAIN_DRV = 5;
   localparam logic [7:0] CTL1_RST = 8'h20;
   // Control 2
   localparam int C2_DET_EN = 0;
   localparam int C2_LOCO_SEL = 1;
   localparam int C2_FLAG = 2;
   localparam int C2_MSTOP = 3;
   localparam int C2_ACTION = 7;
   localparam logic [7:0] CTL2_RST = 8'h02;
   // Mode register
   localparam int MD_LOCK = 1;
   localparam int MD_COUNT_SOURCE_PROTECT = 2;
   localparam int MD_PLL_EN = 3;
   // Peripheral clock select
   localparam int PC_TIMER = 0;
   localparam int PC_SERIAL = 1;
   localparam logic [7:0] PCLK_RST = 8'h03;
   localparam logic [7:0] PCLK_WMASK = 8'h03;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage : cgc_pkg

// File: rtl/cgc_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module cgc_sync (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pin_in,
   output logic level_q,
   output logic rise_q,
   output logic fall_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         level_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         rise_q <= (s2_q == s3_q) && s3_q && !level_q;
         fall_q <= (s2_q == s3_q) && !s3_q && level_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule : cgc_sync

// File: rtl/cgc_clkmux.sv
`timescale 1ns/1ps
// Peripheral full/half-rate clock enables
module cgc_clkmux (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic timer_clock_rate_select,
   input wire logic serial_clock_rate_select,
   output logic timer_clk_en,
   output logic serial_clk_en
);
   logic half_q;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         half_q <= 1'b0;
      end else begin
         half_q <= !half_q;
      end
   end

   // Enables rather than gated clocks keep one clock tree
   assign timer_clk_en = timer_clock_rate_select | half_q;
   assign serial_clk_en = serial_clock_rate_select | half_q;
endmodule : cgc_clkmux

// File: rtl/cgc_top.sv
`timescale 1ns/1ps
module cgc_top (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic osc_det_resetn,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic main_osc_running,
   input wire logic stop_mode_exit,
   output logic osc_stop_irq,
   output logic xout_hold_high,
   output logic main_feedback_off,
   output logic sub_pins_hiz,
   output logic [1:0] cpu_clock_source,
   output logic main_osc_stop,
   output logic fixed_div8_select,
   output logic sub_osc_drive_high,
   output logic main_drive_capacity,
   output logic loco_off,
   output logic pll_enable,
   output logic timer_clk_en,
   output logic serial_clk_en
);
   import cgc_pkg::*;

   logic [7:0] prot_q;
   logic [7:0] ctl0_q;
   logic [7:0] ctl1_q;
   logic [7:0] ctl2_q;
   logic [7:0] mode_q;
   logic [7:0] pclk_q;
   logic rd_done_q;
   logic wr_done_q;
   logic main_up;
   logic main_rise;
   logic main_fall;
   logic wr_acc;
   logic [7:0] wbyte;
   logic unlocked;
   logic lock;
   logic stop_entry;
   logic main_src;
   logic low_speed;
   logic pclk_sel;

   function automatic logic [7:0] lane(input logic [9:0] a,
                                       input logic [31:0] d);
      unique case (a[1:0])
         2'b00: lane = d[7:0];
         2'b01: lane = d[15:8];
         2'b10: lane = d[23:16];
         default: lane = d[31:24];
      endcase
   endfunction : lane

   function automatic logic hit(input logic [9:0] a,
                                input logic [7:0] off);
      hit = (a[9:2] == off[7:2]) && (a[9:8] == 2'b00);
   endfunction : hit

   cgc_sync u_main_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_in(main_osc_running),
      .level_q(main_up),
      .rise_q(main_rise),
      .fall_q(main_fall)
   );

   cgc_clkmux u_clkmux (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .timer_clock_rate_select(pclk_q[PC_TIMER]),
      .serial_clock_rate_select(pclk_q[PC_SERIAL]),
      .timer_clk_en(timer_clk_en),
      .serial_clk_en(serial_clk_en)
   );

   // One wait state: answers one cycle after the request is seen
   assign avs_waitrequest = (avs_read && !rd_done_q)
      || (avs_write && !wr_done_q);
   // Write lands on the edge that ends the wait, as the master sees it
   assign wr_acc = avs_write && wr_done_q;
   // Peripheral select sits at a word index, not a byte offset
   assign pclk_sel = (avs_address[9:2] == BADDR_PCLK[9:2]);
   assign wbyte = lane(avs_address, avs_writedata);
   assign unlocked = prot_q[PROT_UNLOCK];
   assign lock = mode_q[MD_LOCK];
   assign stop_entry = wr_acc && unlocked && hit(avs_address, ADDR_CTL1)
      && wbyte[C1_STOP] && !lock && !mode_q[MD_COUNT_SOURCE_PROTECT];
   assign main_src = !ctl0_q[C0_SUB_SEL] && !ctl2_q[C2_LOCO_SEL]
      && !ctl1_q[C1_PLL_SEL];
   assign low_speed = ctl0_q[C0_SUB_SEL];

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rd_done_q <= 1'b0;
         wr_done_q <= 1'b0;
      end else begin
         rd_done_q <= avs_read && !rd_done_q;
         wr_done_q <= avs_write && !wr_done_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prot_q <= 8'h00;
      end else if (wr_acc && hit(avs_address, ADDR_PROT)) begin
         prot_q <= {7'h00, wbyte[PROT_UNLOCK]};
      end
   end

   // Lock is sticky: software cannot clear it once set
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mode_q <= 8'h00;
      end else if (wr_acc && unlocked && hit(avs_address, ADDR_MODE)) begin
         mode_q[MD_LOCK] <= mode_q[MD_LOCK] | wbyte[MD_LOCK];
         mode_q[MD_COUNT_SOURCE_PROTECT] <= mode_q[MD_COUNT_SOURCE_PROTECT] | wbyte[MD_COUNT_SOURCE_PROTECT];
         if (!lock) begin
            mode_q[MD_PLL_EN] <= wbyte[MD_PLL_EN];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctl0_q <= CTL0_RST;
      end else begin
         if (wr_acc && unlocked && hit(avs_address, ADDR_CTL0)) begin
            ctl0_q[C0_SUB_PIN] <= wbyte[C0_SUB_PIN];
            ctl0_q[C0_SUB_DRV] <= wbyte[C0_SUB_DRV];
            ctl0_q[C0_DIV8] <= wbyte[C0_DIV8];
            if (!lock) begin
               ctl0_q[C0_MAIN_WAIT] <= wbyte[C0_MAIN_WAIT];
               ctl0_q[C0_MAIN_STOP] <= wbyte[C0_MAIN_STOP];
               ctl0_q[C0_SUB_SEL] <= wbyte[C0_SUB_SEL];
            end
         end
         if (!ctl0_q[C0_SUB_PIN] || stop_entry) begin
            ctl0_q[C0_SUB_DRV] <= 1'b1;
         end
         if (stop_entry) begin
            ctl0_q[C0_DIV8] <= 1'b1;
         end
         if (ctl0_q[C0_MAIN_STOP]
             && (ctl0_q[C0_SUB_SEL] || !ctl2_q[C2_LOCO_SEL])) begin
            ctl0_q[C0_DIV8] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctl1_q <= CTL1_RST;
      end else begin
         if (wr_acc && unlocked && hit(avs_address, ADDR_CTL1)) begin
            ctl1_q[C1_MAIN_DRV] <= wbyte[C1_MAIN_DRV];
            if (!lock) begin
               ctl1_q[C1_PLL_SEL] <= wbyte[C1_PLL_SEL];
            end
            if (stop_entry) begin
               ctl1_q[C1_STOP] <= 1'b1;
            end
            // Forced-on cases below override an attempt to set it
            ctl1_q[C1_LOCO_OFF] <= wbyte[C1_LOCO_OFF];
         end
         if (stop_exit_seen()) begin
            ctl1_q[C1_STOP] <= 1'b0;
         end
         if (stop_entry || (ctl0_q[C0_MAIN_STOP] && low_speed)) begin
            ctl1_q[C1_MAIN_DRV] <= 1'b1;
         end
         if (ctl0_q[C0_MAIN_STOP]
             && (ctl0_q[C0_SUB_SEL] || !ctl2_q[C2_LOCO_SEL])) begin
            ctl1_q[C1_MAIN_DRV] <= 1'b1;
         end
         if (ctl2_q[C2_LOCO_SEL]) begin
            ctl1_q[C1_LOCO_OFF] <= 1'b0;
         end
         if (mode_q[MD_COUNT_SOURCE_PROTECT]) begin
            ctl1_q[C1_LOCO_OFF] <= 1'b0;
         end
      end
   end

   function automatic logic stop_exit_seen();
      stop_exit_seen = stop_mode_exit;
   endfunction : stop_exit_seen

   // Detection-reset keeps enable, LOCO select and action
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctl2_q <= CTL2_RST;
      end else if (!osc_det_resetn) begin
         ctl2_q[C2_FLAG] <= 1'b0;
      end else begin
         if (wr_acc && unlocked && hit(avs_address, ADDR_CTL2)) begin
            ctl2_q[C2_ACTION] <= wbyte[C2_ACTION];
            ctl2_q[C2_LOCO_SEL] <= wbyte[C2_LOCO_SEL];
            if (!lock) begin
               ctl2_q[C2_DET_EN] <= wbyte[C2_DET_EN];
            end
            if (!wbyte[C2_FLAG]) begin
               ctl2_q[C2_FLAG] <= 1'b0;
            end
         end
         ctl2_q[C2_MSTOP] <= !main_up;
         if (ctl2_q[C2_DET_EN] && (main_fall || main_rise)) begin
            ctl2_q[C2_FLAG] <= 1'b1;
         end
         if (ctl2_q[C2_DET_EN] && ctl2_q[C2_ACTION] && main_fall
             && main_src) begin
            ctl2_q[C2_LOCO_SEL] <= 1'b1;
         end
      end
   end

   // With PLL as source the LOCO select is left alone by design
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         osc_stop_irq <= 1'b0;
      end else begin
         osc_stop_irq <= ctl2_q[C2_DET_EN] && ctl2_q[C2_ACTION]
            && (main_fall || main_rise) && !ctl2_q[C2_FLAG];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pclk_q <= PCLK_RST;
      end else if (wr_acc && unlocked && pclk_sel) begin
         pclk_q <= wbyte & PCLK_WMASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !rd_done_q) begin
         unique case (1'b1)
            hit(avs_address, ADDR_PROT): avs_readdata <= {24'h0, prot_q};
            hit(avs_address, ADDR_CTL0): avs_readdata <= {24'h0, ctl0_q};
            hit(avs_address, ADDR_CTL1): avs_readdata <= {24'h0, ctl1_q};
            hit(avs_address, ADDR_CTL2): avs_readdata <= {24'h0, ctl2_q};
            hit(avs_address, ADDR_MODE): avs_readdata <= {24'h0, mode_q};
            pclk_sel: avs_readdata <= {24'h0, pclk_q};
            default: avs_readdata <= UNMAPPED_RD;
         endcase
      end
   end

   assign xout_hold_high = ctl1_q[C1_STOP] || ctl0_q[C0_MAIN_STOP];
   assign main_feedback_off = ctl1_q[C1_STOP];
   assign sub_pins_hiz = ctl1_q[C1_STOP];
   assign cpu_clock_source = ctl0_q[C0_SUB_SEL] ? 2'h1
      : ctl2_q[C2_LOCO_SEL] ? 2'h2
      : ctl1_q[C1_PLL_SEL] ? 2'h3 : 2'h0;
   assign main_osc_stop = ctl0_q[C0_MAIN_STOP];
   assign fixed_div8_select = ctl0_q[C0_DIV8];
   assign sub_osc_drive_high = ctl0_q[C0_SUB_DRV];
   assign main_drive_capacity = ctl1_q[C1_MAIN_DRV];
   assign loco_off = ctl1_q[C1_LOCO_OFF];
   assign pll_enable = mode_q[MD_PLL_EN];
endmodule : cgc_top

// File: sim/cgc_top_sva.sv
`timescale 1ns/1ps
module cgc_top_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic osc_stop_irq,
   input wire logic xout_hold_high,
   input wire logic main_feedback_off,
   input wire logic sub_pins_hiz,
   input wire logic [1:0] cpu_clock_source,
   input wire logic main_osc_stop,
   input wire logic fixed_div8_select,
   input wire logic sub_osc_drive_high,
   input wire logic main_drive_capacity,
   input wire logic loco_off,
   input wire logic pll_enable,
   input wire logic timer_clk_en,
   input wire logic serial_clk_en
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   wait_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered after one wait");
   rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
      else $error("read data changed without a read");
   reset_vals_a: assert property ($rose(resetn) |-> fixed_div8_select &&
      sub_osc_drive_high && main_drive_capacity && !main_osc_stop && !loco_off
      && !pll_enable && cpu_clock_source == 2'h2) else $error("bad reset state");
   stop_pins_a: assert property (sub_pins_hiz && $past(sub_pins_hiz) |->
      xout_hold_high && main_feedback_off && fixed_div8_select &&
      main_drive_capacity && sub_osc_drive_high) else $error("stop state wrong");
   main_stop_forced_a: assert property (main_osc_stop && $past(main_osc_stop)
      && cpu_clock_source != 2'h2 |-> fixed_div8_select && main_drive_capacity)
      else $error("div8 or drive not held with main stopped");
   loco_run_a: assert property (cpu_clock_source == 2'h2 &&
      $past(cpu_clock_source) == 2'h2 |-> !loco_off)
      else $error("on-chip oscillator off while selected");
   irq_single_a: assert property (osc_stop_irq |=> !osc_stop_irq [*8])
      else $error("interrupt repeated while flag set");
   timer_half_a: assert property (!timer_clk_en |=> timer_clk_en)
      else $error("timer enable low twice");
   serial_half_a: assert property (!serial_clk_en |=> serial_clk_en)
      else $error("serial enable low twice");
   cover property (osc_stop_irq);
   cover property (sub_pins_hiz);
   cover property (cpu_clock_source == 2'h3);
endmodule : cgc_top_chk

bind cgc_top cgc_top_chk u_cgc_top_chk (.*);

// File: sim/tb_cgc_top.sv
`timescale 1ns/1ps
module tb_cgc_top;
   import cgc_pkg::*;
   localparam logic [9:0] A_PROT = {2'b00, ADDR_PROT};
   localparam logic [9:0] A_CTL0 = {2'b00, ADDR_CTL0};
   localparam logic [9:0] A_CTL1 = {2'b00, ADDR_CTL1};
   localparam logic [9:0] A_CTL2 = {2'b00, ADDR_CTL2};
   localparam logic [9:0] A_MODE = {2'b00, ADDR_MODE};
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic osc_det_resetn = 1'b1;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h1;
   logic main_osc_running = 1'b1;
   logic stop_mode_exit = 1'b0;
   logic [31:0] avs_readdata, m_cur;
   logic avs_waitrequest, osc_stop_irq, xout_hold_high, main_feedback_off;
   logic sub_pins_hiz, main_osc_stop, fixed_div8_select, sub_osc_drive_high;
   logic main_drive_capacity, loco_off, pll_enable, timer_clk_en;
   logic serial_clk_en;
   logic [1:0] cpu_clock_source, v, r;
   int n_fail = 0;
   int checks_done = 0;
   int n_irq = 0;
   int seed = 25213;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];

   cgc_top u_cgc_top (.*);

   initial forever #2.5 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // Entered just after a rising edge; a read notes its expectation first
   task automatic bus(input logic rd, input logic [9:0] a,
                      input logic [7:0] d, input logic [7:0] m);
      int n;
      n = 0;
      if (rd) begin
         exp_q.push_back({24'h0, d});
         msk_q.push_back({24'h0, m});
      end
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      chk({31'h0, avs_waitrequest}, 32'h0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic settle;
      repeat (3) @(posedge clk_sys);
   endtask : settle

   // Detector needs several cycles through the pin synchroniser
   task automatic osc(input logic run);
      main_osc_running <= run;
      repeat (20) @(posedge clk_sys);
   endtask : osc

   task automatic rate(input logic [1:0] sel);
      int t, s;
      t = 0;
      s = 0;
      repeat (8) begin
         @(posedge clk_sys);
         t += timer_clk_en;
         s += serial_clk_en;
      end
      chk(t, sel[PC_TIMER] ? 8 : 4);
      chk(s, sel[PC_SERIAL] ? 8 : 4);
   endtask : rate

   always @(posedge clk_sys) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         m_cur = msk_q.pop_front();
         chk(avs_readdata & m_cur, exp_q.pop_front() & m_cur);
      end
      if (osc_stop_irq === 1'b1) n_irq++;
   end

   initial begin
      #50000;
      n_fail++;
      finish_test;
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      bus(1, A_PROT, 8'h00, 8'hff);
      bus(1, A_CTL0, CTL0_RST, 8'hff);
      bus(1, A_CTL1, CTL1_RST, 8'hff);
      bus(1, A_CTL2, CTL2_RST, 8'hff);
      bus(1, A_MODE, 8'h00, 8'hff);
      bus(1, BADDR_PCLK, PCLK_RST, PCLK_WMASK);
      bus(1, 10'h03c, 8'h00, 8'hff);
      bus(0, BADDR_PCLK, 8'h00, 8'h00);
      bus(1, BADDR_PCLK, PCLK_RST, PCLK_WMASK);
      bus(0, A_PROT, 8'h01, 8'h00);
      r = 2'($random(seed));
      for (int i = 0; i < 4; i++) begin
         v = r ^ i[1:0];
         bus(0, BADDR_PCLK, {6'h0, v}, 8'h00);
         bus(1, BADDR_PCLK, {6'h0, v}, PCLK_WMASK);
         rate(v);
      end
      bus(0, A_CTL1, 8'h30, 8'h00);
      settle;
      chk({31'h0, loco_off}, 32'h0);
      bus(0, A_CTL2, 8'h00, 8'h00);
      bus(0, A_CTL1, 8'h30, 8'h00);
      settle;
      chk({29'h0, loco_off, cpu_clock_source}, 32'h4);
      bus(0, A_MODE, 8'h08, 8'h00);
      repeat (50) @(posedge clk_sys);
      bus(0, A_CTL2, 8'h02, 8'h00);
      bus(0, A_CTL1, 8'h22, 8'h00);
      settle;
      chk({29'h0, loco_off, cpu_clock_source}, 32'h2);
      bus(0, A_CTL2, 8'h00, 8'h00);
      settle;
      chk({29'h0, pll_enable, cpu_clock_source}, 32'h7);
      bus(0, A_CTL2, 8'h81, 8'h00);
      osc(1'b0);
      chk(n_irq, 1);
      chk({30'h0, cpu_clock_source}, 32'h3);
      bus(1, A_CTL2, 8'h8d, 8'hff);
      osc(1'b1);
      chk(n_irq, 1);
      bus(0, A_CTL2, 8'h85, 8'h00);
      bus(1, A_CTL2, 8'h85, 8'hff);
      bus(0, A_CTL2, 8'h81, 8'h00);
      bus(1, A_CTL2, 8'h81, 8'hff);
      bus(0, A_CTL1, 8'h20, 8'h00);
      osc(1'b0);
      chk(n_irq, 2);
      chk({30'h0, cpu_clock_source}, 32'h2);
      bus(1, A_CTL2, 8'h8f, 8'hff);
      osc_det_resetn <= 1'b0;
      @(posedge clk_sys);
      osc_det_resetn <= 1'b1;
      bus(1, A_CTL2, 8'h8b, 8'hff);
      osc(1'b1);
      chk(n_irq, 3);
      bus(0, A_CTL2, 8'h00, 8'h00);
      bus(0, A_CTL0, 8'h08, 8'h00);
      bus(0, A_CTL1, 8'h01, 8'h00);
      settle;
      chk({26'h0, xout_hold_high, main_feedback_off, sub_pins_hiz,
           fixed_div8_select, main_drive_capacity, sub_osc_drive_high},
          32'h3f);
      stop_mode_exit <= 1'b1;
      @(posedge clk_sys);
      stop_mode_exit <= 1'b0;
      settle;
      chk({31'h0, sub_pins_hiz}, 32'h0);
      bus(0, A_CTL1, 8'h00, 8'h00);
      bus(0, A_CTL0, 8'h20, 8'h00);
      settle;
      chk({29'h0, main_osc_stop, fixed_div8_select, main_drive_capacity},
          32'h7);
      bus(0, A_CTL0, 8'h08, 8'h00);
      bus(0, A_CTL1, 8'h10, 8'h00);
      bus(0, A_MODE, 8'h0c, 8'h00);
      settle;
      chk({31'h0, loco_off}, 32'h0);
      bus(0, A_CTL1, 8'h11, 8'h00);
      settle;
      chk({30'h0, loco_off, sub_pins_hiz}, 32'h0);
      bus(0, A_MODE, 8'h0e, 8'h00);
      bus(0, A_CTL0, 8'h28, 8'h00);
      bus(0, A_CTL1, 8'h02, 8'h00);
      bus(0, A_CTL2, 8'h01, 8'h00);
      settle;
      chk({29'h0, main_osc_stop, cpu_clock_source}, 32'h0);
      bus(1, A_CTL2, 8'h00, 8'h01);
      finish_test;
   end
endmodule : tb_cgc_top
